//--- design/bprs_pkg.sv
// Shared constants and types for the baseboard power and reset sequencer
package bprs_pkg;

    // Number of accelerator module slots
    localparam int NUM_SLOTS = 8;

    // Clock rate of the auxiliary-domain clock
    localparam int CLK_HZ = 50_000_000;

    // Least wait from rails good to link reset release, in ms
    localparam int RELEASE_DELAY_MS = 100;
    // Longest wait for rails good to fall after enable drop, in ms
    localparam int OFF_TIMEOUT_MS = 100;

    // Cycle counts derived from the times above
    localparam int RELEASE_CYCLES = RELEASE_DELAY_MS * (CLK_HZ / 1000);
    localparam int OFF_TIMEOUT_CYCLES = OFF_TIMEOUT_MS * (CLK_HZ / 1000);

    // Reset values of the outputs
    localparam logic RST_ENABLE = 1'h0;
    localparam logic RST_RESET_N = 1'h0;
    localparam logic RST_REQUEST_N = 1'h1;
    localparam logic RST_MUX_SLOT0 = 1'h0;

    // Sequencer states
    typedef enum logic [4:0] {
        BPRS_ST_OFF     = 5'h01,
        BPRS_ST_RAMP    = 5'h02,
        BPRS_ST_ON      = 5'h04,
        BPRS_ST_DOWN    = 5'h08,
        BPRS_ST_CLKSTOP = 5'h10
    } bprs_seq_state_t;

    // Management controller states
    typedef enum logic [6:0] {
        BPRS_HC_OFF      = 7'h01,
        BPRS_HC_COPY_OFF = 7'h02,
        BPRS_HC_ON       = 7'h04,
        BPRS_HC_RST_MUX  = 7'h08,
        BPRS_HC_RST_COPY = 7'h10,
        BPRS_HC_RST_REL  = 7'h20,
        BPRS_HC_RST_END  = 7'h40
    } bprs_ctl_state_t;

endpackage

//--- design/bprs_if.sv
// Link between the baseboard sequencer and the controller with its modules
`timescale 1ns/10ps
`default_nettype none

interface bprs_if;
    logic board_power_request_n;
    logic board_power_ready;
    logic [bprs_pkg::NUM_SLOTS-1:0] slot_power_enable;
    logic [bprs_pkg::NUM_SLOTS-1:0] slot_rails_good;
    logic [bprs_pkg::NUM_SLOTS-1:0] slot_link_reset_n;
    logic [bprs_pkg::NUM_SLOTS-1:0] slot_soft_reset_n;
    logic [bprs_pkg::NUM_SLOTS-1:0] slot_reset_hold;

    modport dev (
        input board_power_request_n,
        input slot_rails_good,
        input slot_reset_hold,
        output board_power_ready,
        output slot_power_enable,
        output slot_link_reset_n,
        output slot_soft_reset_n
    );

    modport host (
        output board_power_request_n,
        output slot_rails_good,
        output slot_reset_hold,
        input board_power_ready,
        input slot_power_enable,
        input slot_link_reset_n,
        input slot_soft_reset_n
    );
endinterface

`default_nettype wire

//--- design/bprs_sequencer.sv
// Baseboard power and reset sequencer for eight module slots
// How it works
// - Slot enables only after board rails good
// - Reference clocks run while planes ramp
// - Module raises rails good once supplies good
// - Link reset held 100 ms past rails good
// - Soft reset released with or after link reset
// - Stop reference clocks before aux regulator off, both at once on timeout
// - Sequencer drives reference clock buffer enables
// - Rails good still high 100 ms: all off
// - Power request input starts up or down
// - Controller owns shared eeprom while power off
// - Shared eeprom goes to slot zero when on
// - Controller refreshes shared copy if primary changed
// - Slot zero reads topology once granted eeprom
// - Module reset: hold, mux, copy, mux, release
// - Primary edits wait for power off or reset
// - Eight independent active low link resets
// - Host pulls power request low to power on
// - Board power ready driven back to controller
`timescale 1ns/10ps
`default_nettype none

module bprs_sequencer #(
    parameter int RELEASE_CYCLES = bprs_pkg::RELEASE_CYCLES,
    parameter int OFF_TIMEOUT_CYCLES = bprs_pkg::OFF_TIMEOUT_CYCLES
) (
    input wire logic clk, // Auxiliary-domain clock
    input wire logic nrst, // Asynchronous reset, active low
    bprs_if.dev link, // Controller and module side
    input wire logic board_rails_good, // All board rails in regulation
    output logic aux_rail_regulator_enable, // Aux 3.3 V regulator enable
    output logic refclk_buffer_enable, // Reference clock buffer enable
    output logic shutdown_fault // Power-off timeout shut all down
);

    localparam int NS = bprs_pkg::NUM_SLOTS;
    localparam int MAXC = (RELEASE_CYCLES > OFF_TIMEOUT_CYCLES) ?
        RELEASE_CYCLES : OFF_TIMEOUT_CYCLES;
    localparam int CW = $clog2(MAXC + 1);
    localparam logic [CW-1:0] REL_CNT = CW'(RELEASE_CYCLES);
    localparam logic [CW-1:0] OFF_CNT = CW'(OFF_TIMEOUT_CYCLES);

    typedef struct packed {
        bprs_pkg::bprs_seq_state_t st;
        logic req_s1;
        logic req_s2;
        logic rails_s1;
        logic rails_s2;
        logic [NS-1:0] rg_s1;
        logic [NS-1:0] rg_s2;
        logic [NS-1:0] hold_s1;
        logic [NS-1:0] hold_s2;
        logic [NS-1:0][CW-1:0] cnt;
        logic [NS-1:0] en;
        logic [NS-1:0] link_rst_n;
        logic [NS-1:0] soft_rst_n;
        logic ready;
        logic aux_en;
        logic clk_en;
        logic fault;
    } bprs_seq_regs_t;

    localparam bprs_seq_regs_t REGS_RESET = '{
        st: bprs_pkg::BPRS_ST_OFF,
        req_s1: bprs_pkg::RST_REQUEST_N,
        req_s2: bprs_pkg::RST_REQUEST_N,
        rails_s1: 1'h0,
        rails_s2: 1'h0,
        rg_s1: '0,
        rg_s2: '0,
        hold_s1: '0,
        hold_s2: '0,
        cnt: '0,
        en: {NS{bprs_pkg::RST_ENABLE}},
        link_rst_n: {NS{bprs_pkg::RST_RESET_N}},
        soft_rst_n: {NS{bprs_pkg::RST_RESET_N}},
        ready: 1'h0,
        aux_en: 1'h0,
        clk_en: 1'h0,
        fault: 1'h0
    };

    bprs_seq_regs_t q_r;
    bprs_seq_regs_t q_nxt;

    // Next-state logic: synchronisers, sequence, per-slot timers
    always_comb begin
        logic any_timeout;
        any_timeout = 1'h0;
        q_nxt = q_r;
        // Pin inputs pass two flip-flops first
        q_nxt.req_s1 = link.board_power_request_n;
        q_nxt.req_s2 = q_r.req_s1;
        q_nxt.rails_s1 = board_rails_good;
        q_nxt.rails_s2 = q_r.rails_s1;
        q_nxt.rg_s1 = link.slot_rails_good;
        q_nxt.rg_s2 = q_r.rg_s1;
        q_nxt.hold_s1 = link.slot_reset_hold;
        q_nxt.hold_s2 = q_r.hold_s1;
        case (q_r.st)
            bprs_pkg::BPRS_ST_OFF: begin
                q_nxt.en = '0;
                q_nxt.link_rst_n = '0;
                q_nxt.soft_rst_n = '0;
                q_nxt.ready = 1'h0;
                if (!q_r.req_s2) begin
                    // Ramp the planes with reference clocks running
                    q_nxt.st = bprs_pkg::BPRS_ST_RAMP;
                    q_nxt.aux_en = 1'h1;
                    q_nxt.clk_en = 1'h1;
                    q_nxt.fault = 1'h0;
                end
            end
            bprs_pkg::BPRS_ST_RAMP: begin
                if (q_r.req_s2) begin
                    q_nxt.st = bprs_pkg::BPRS_ST_DOWN;
                    q_nxt.cnt = '0;
                end else if (q_r.rails_s2) begin
                    // Enables only once every board rail is good
                    q_nxt.st = bprs_pkg::BPRS_ST_ON;
                    q_nxt.en = '1;
                    q_nxt.ready = 1'h1;
                    q_nxt.cnt = '0;
                end
            end
            bprs_pkg::BPRS_ST_ON: begin
                if (q_r.req_s2 || !q_r.rails_s2) begin
                    // Resets fall in the same edge as enables
                    q_nxt.st = bprs_pkg::BPRS_ST_DOWN;
                    q_nxt.en = '0;
                    q_nxt.link_rst_n = '0;
                    q_nxt.soft_rst_n = '0;
                    q_nxt.ready = 1'h0;
                    q_nxt.cnt = '0;
                end else begin
                    for (int i = 0; i < NS; i++) begin
                        // Each slot times its own release delay
                        if (!q_r.rg_s2[i]) begin
                            q_nxt.cnt[i] = '0;
                        end else if (q_r.cnt[i] != REL_CNT) begin
                            q_nxt.cnt[i] = q_r.cnt[i] + 1'b1;
                        end
                        // Both resets release on one edge
                        q_nxt.link_rst_n[i] = q_r.rg_s2[i] &&
                            (q_r.cnt[i] == REL_CNT) &&
                            !q_r.hold_s2[i];
                        q_nxt.soft_rst_n[i] = q_r.rg_s2[i] &&
                            (q_r.cnt[i] == REL_CNT) &&
                            !q_r.hold_s2[i];
                    end
                end
            end
            bprs_pkg::BPRS_ST_DOWN: begin
                for (int i = 0; i < NS; i++) begin
                    // Time how long rails good stays high
                    if (!q_r.rg_s2[i]) begin
                        q_nxt.cnt[i] = '0;
                    end else if (q_r.cnt[i] != OFF_CNT) begin
                        q_nxt.cnt[i] = q_r.cnt[i] + 1'b1;
                    end
                    if (q_r.rg_s2[i] && (q_r.cnt[i] == OFF_CNT)) begin
                        any_timeout = 1'h1;
                    end
                end
                if (any_timeout) begin
                    // Stuck module: cut every supply at once
                    q_nxt.st = bprs_pkg::BPRS_ST_OFF;
                    q_nxt.aux_en = 1'h0;
                    q_nxt.clk_en = 1'h0;
                    q_nxt.fault = 1'h1;
                end else if (q_r.rg_s2 == '0) begin
                    // Clocks stop one edge before the regulator
                    q_nxt.st = bprs_pkg::BPRS_ST_CLKSTOP;
                    q_nxt.clk_en = 1'h0;
                end
            end
            bprs_pkg::BPRS_ST_CLKSTOP: begin
                q_nxt.st = bprs_pkg::BPRS_ST_OFF;
                q_nxt.aux_en = 1'h0;
            end
            default: begin
                q_nxt = REGS_RESET;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= REGS_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign link.board_power_ready = q_r.ready;
    assign link.slot_power_enable = q_r.en;
    assign link.slot_link_reset_n = q_r.link_rst_n;
    assign link.slot_soft_reset_n = q_r.soft_rst_n;
    assign aux_rail_regulator_enable = q_r.aux_en;
    assign refclk_buffer_enable = q_r.clk_en;
    assign shutdown_fault = q_r.fault;

endmodule

`default_nettype wire

//--- design/bprs_controller.sv
// Management controller and module side of the power and reset link
`timescale 1ns/10ps
`default_nettype none

module bprs_controller (
    input wire logic clk, // Controller clock
    input wire logic nrst, // Asynchronous reset, active low
    bprs_if.host link, // Sequencer side
    input wire logic power_on_cmd, // Level: board power wanted
    input wire logic [bprs_pkg::NUM_SLOTS-1:0] module_supplies_ok, // Rails
    input wire logic [bprs_pkg::NUM_SLOTS-1:0] slot_hold_cmd, // Hold reset
    input wire logic slot0_reset_cmd, // Pulse: reset slot zero
    input wire logic primary_edited, // Pulse: primary eeprom changed
    input wire logic copy_done, // Pulse: eeprom copy finished
    output logic eeprom_mux_to_slot0, // 1 slot zero, 0 controller
    output logic eeprom_copy_start, // Pulse: start primary to shared copy
    output logic topology_fetch, // Pulse: slot zero reads topology
    output logic copy_pending, // Primary edit not yet copied
    output logic dc_on // Board power ready seen
);

    localparam int NS = bprs_pkg::NUM_SLOTS;

    typedef struct packed {
        bprs_pkg::bprs_ctl_state_t st;
        logic rdy_s1;
        logic rdy_s2;
        logic [NS-1:0] en_s1;
        logic [NS-1:0] en_s2;
        logic [NS-1:0] rg;
        logic req_n;
        logic [NS-1:0] hold;
        logic hold0;
        logic mux;
        logic copy_start;
        logic fetch;
        logic pending;
    } bprs_ctl_regs_t;

    localparam bprs_ctl_regs_t REGS_RESET = '{
        st: bprs_pkg::BPRS_HC_OFF,
        rdy_s1: 1'h0,
        rdy_s2: 1'h0,
        en_s1: '0,
        en_s2: '0,
        rg: '0,
        req_n: bprs_pkg::RST_REQUEST_N,
        hold: '0,
        hold0: 1'h0,
        mux: bprs_pkg::RST_MUX_SLOT0,
        copy_start: 1'h0,
        fetch: 1'h0,
        pending: 1'h0
    };

    bprs_ctl_regs_t q_r;
    bprs_ctl_regs_t q_nxt;

    // Next-state logic: request, rails good and eeprom steering
    always_comb begin
        logic clr;
        clr = 1'h0;
        q_nxt = q_r;
        q_nxt.rdy_s1 = link.board_power_ready;
        q_nxt.rdy_s2 = q_r.rdy_s1;
        q_nxt.en_s1 = link.slot_power_enable;
        q_nxt.en_s2 = q_r.en_s1;
        q_nxt.req_n = !power_on_cmd;
        q_nxt.rg = module_supplies_ok & q_r.en_s2;
        q_nxt.copy_start = 1'h0;
        q_nxt.fetch = 1'h0;
        case (q_r.st)
            bprs_pkg::BPRS_HC_OFF: begin
                q_nxt.mux = 1'h0;
                if (q_r.pending) begin
                    q_nxt.copy_start = 1'h1;
                    clr = 1'h1;
                    q_nxt.st = bprs_pkg::BPRS_HC_COPY_OFF;
                end else if (q_r.rdy_s2) begin
                    q_nxt.mux = 1'h1;
                    q_nxt.fetch = 1'h1;
                    q_nxt.st = bprs_pkg::BPRS_HC_ON;
                end
            end
            bprs_pkg::BPRS_HC_COPY_OFF: begin
                if (copy_done) begin
                    q_nxt.st = bprs_pkg::BPRS_HC_OFF;
                end
            end
            bprs_pkg::BPRS_HC_ON: begin
                if (!q_r.rdy_s2) begin
                    q_nxt.mux = 1'h0;
                    q_nxt.st = bprs_pkg::BPRS_HC_OFF;
                end else if (slot0_reset_cmd) begin
                    q_nxt.hold0 = 1'h1;
                    q_nxt.st = bprs_pkg::BPRS_HC_RST_MUX;
                end
            end
            bprs_pkg::BPRS_HC_RST_MUX: begin
                q_nxt.mux = 1'h0;
                if (q_r.pending) begin
                    q_nxt.copy_start = 1'h1;
                    clr = 1'h1;
                    q_nxt.st = bprs_pkg::BPRS_HC_RST_COPY;
                end else begin
                    q_nxt.st = bprs_pkg::BPRS_HC_RST_REL;
                end
            end
            bprs_pkg::BPRS_HC_RST_COPY: begin
                if (copy_done) begin
                    q_nxt.st = bprs_pkg::BPRS_HC_RST_REL;
                end
            end
            bprs_pkg::BPRS_HC_RST_REL: begin
                q_nxt.mux = 1'h1;
                q_nxt.fetch = 1'h1;
                q_nxt.st = bprs_pkg::BPRS_HC_RST_END;
            end
            bprs_pkg::BPRS_HC_RST_END: begin
                q_nxt.hold0 = 1'h0;
                q_nxt.st = bprs_pkg::BPRS_HC_ON;
            end
            default: begin
                q_nxt.st = bprs_pkg::BPRS_HC_OFF;
            end
        endcase
        // A new edit in the clearing cycle wins
        q_nxt.pending = (q_r.pending && !clr) || primary_edited;
        q_nxt.hold = slot_hold_cmd;
        q_nxt.hold[0] = slot_hold_cmd[0] || q_nxt.hold0;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= REGS_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign link.board_power_request_n = q_r.req_n;
    assign link.slot_rails_good = q_r.rg;
    assign link.slot_reset_hold = q_r.hold;
    assign eeprom_mux_to_slot0 = q_r.mux;
    assign eeprom_copy_start = q_r.copy_start;
    assign topology_fetch = q_r.fetch;
    assign copy_pending = q_r.pending;
    assign dc_on = q_r.rdy_s2;

endmodule

`default_nettype wire

//--- tb/bprs_checker.sv
// Assertions on the link between the sequencer and the controller
`timescale 1ns/10ps
`default_nettype none

module bprs_checker #(
    parameter int RELEASE_CYCLES = bprs_pkg::RELEASE_CYCLES
) (
    input wire logic clk, // Auxiliary-domain clock
    input wire logic nrst, // Reset, active low
    input wire logic board_power_request_n, // Power wanted, low
    input wire logic board_power_ready, // Board on
    input wire logic [7:0] slot_power_enable, // Slot enables
    input wire logic [7:0] slot_rails_good, // Module rails good
    input wire logic [7:0] slot_link_reset_n, // Link resets
    input wire logic [7:0] slot_soft_reset_n, // Soft resets
    input wire logic board_rails_good, // Board rails good
    input wire logic aux_rail_regulator_enable, // Aux regulator on
    input wire logic refclk_buffer_enable // Reference clocks on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Ready only once board rails have been good
    property p_ready_after_rails;
        $rose(board_power_ready) |-> $past(board_rails_good, 2);
    endproperty
    a_ready_after_rails: assert property (p_ready_after_rails)
        else $error("slot enables raised without board rails good");

    // Reference clocks start with the aux regulator
    property p_clocks_with_aux;
        $rose(aux_rail_regulator_enable) |-> refclk_buffer_enable;
    endproperty
    a_clocks_with_aux: assert property (p_clocks_with_aux)
        else $error("aux regulator on without reference clocks");

    // Power request from the off state starts power-up
    property p_request_starts;
        $fell(board_power_request_n) && !aux_rail_regulator_enable
            && !refclk_buffer_enable |-> ##3 aux_rail_regulator_enable;
    endproperty
    a_request_starts: assert property (p_request_starts)
        else $error("power request did not start power-up");

    // Ready stands exactly while all slot enables stand
    property p_ready_enables;
        slot_power_enable == {8{board_power_ready}};
    endproperty
    a_ready_enables: assert property (p_ready_enables)
        else $error("ready and slot enables disagree");

    // Soft reset never released ahead of link reset
    property p_soft_after_link;
        (slot_soft_reset_n & ~slot_link_reset_n) == 8'h00;
    endproperty
    a_soft_after_link: assert property (p_soft_after_link)
        else $error("soft reset released before link reset");

    // An unpowered slot is always held in reset
    property p_reset_unpowered;
        (slot_link_reset_n & ~slot_power_enable) == 8'h00;
    endproperty
    a_reset_unpowered: assert property (p_reset_unpowered)
        else $error("link reset released on unpowered slot");

    // Reference clocks stop one edge before the aux regulator
    property p_clock_stop_first;
        $fell(aux_rail_regulator_enable) |-> !$past(refclk_buffer_enable);
    endproperty
    a_clock_stop_first: assert property (p_clock_stop_first)
        else $error("aux regulator off while reference clocks ran");

    // Per-slot count of cycles with rails good held high
    for (genvar i = 0; i < 8; i++) begin : g_slot
        // Wide enough for the full release delay at the real clock rate
        logic [31:0] good_cnt_r;
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                good_cnt_r <= 32'h0;
            end else if (!slot_rails_good[i]) begin
                good_cnt_r <= 32'h0;
            end else if (good_cnt_r != 32'hFFFFFFFF) begin
                good_cnt_r <= good_cnt_r + 32'h1;
            end
        end
        property p_link_delay;
            $rose(slot_link_reset_n[i]) |-> good_cnt_r >= RELEASE_CYCLES;
        endproperty
        a_link_delay: assert property (p_link_delay)
            else $error("link reset released too early");
    end

    c_power_up: cover property ($rose(board_power_ready));
    c_link_free: cover property ($rose(slot_link_reset_n[0]));
    c_power_off: cover property ($fell(aux_rail_regulator_enable));
endmodule

`default_nettype wire

//--- tb/bprs_sequencer_bench.sv
// Bench: sequencer and controller joined, second sequencer on a bad module
`timescale 1ns/10ps
`default_nettype none

module bprs_sequencer_bench;
    localparam int RC = 20;
    localparam int TC = 30;
    // Rows: module supplies, hold commands, expected link resets
    localparam logic [23:0] ROWS [6] = '{24'hFF00FF, 24'hA500A5,
        24'hFF0FF0, 24'h3C803C, 24'h00FF00, 24'hFF00FF};
    logic clk, nrst, brg, pon, rst0, edit, cdone;
    logic aux, refclk, fault, aux2, refclk2, fault2;
    logic mux, cstart, fetch, pend, dc_on;
    logic [7:0] sup, hold;
    int n_fail, n_checks, cyc, k, j;

    bprs_if bprs_if_i ();
    bprs_if bprs_if_i2 ();
    bprs_sequencer #(.RELEASE_CYCLES(RC), .OFF_TIMEOUT_CYCLES(TC))
        bprs_sequencer_i (.clk(clk), .nrst(nrst), .link(bprs_if_i),
        .board_rails_good(brg), .aux_rail_regulator_enable(aux),
        .refclk_buffer_enable(refclk), .shutdown_fault(fault));
    bprs_sequencer #(.RELEASE_CYCLES(RC), .OFF_TIMEOUT_CYCLES(TC))
        bprs_sequencer_i2 (.clk(clk), .nrst(nrst), .link(bprs_if_i2),
        .board_rails_good(brg), .aux_rail_regulator_enable(aux2),
        .refclk_buffer_enable(refclk2), .shutdown_fault(fault2));
    bprs_controller bprs_controller_i (.clk(clk), .nrst(nrst),
        .link(bprs_if_i), .power_on_cmd(pon), .module_supplies_ok(sup),
        .slot_hold_cmd(hold), .slot0_reset_cmd(rst0),
        .primary_edited(edit), .copy_done(cdone),
        .eeprom_mux_to_slot0(mux), .eeprom_copy_start(cstart),
        .topology_fetch(fetch), .copy_pending(pend), .dc_on(dc_on));
    bprs_checker #(.RELEASE_CYCLES(RC)) bprs_checker_i (.clk(clk),
        .nrst(nrst),
        .board_power_request_n(bprs_if_i.board_power_request_n),
        .board_power_ready(bprs_if_i.board_power_ready),
        .slot_power_enable(bprs_if_i.slot_power_enable),
        .slot_rails_good(bprs_if_i.slot_rails_good),
        .slot_link_reset_n(bprs_if_i.slot_link_reset_n),
        .slot_soft_reset_n(bprs_if_i.slot_soft_reset_n),
        .board_rails_good(brg), .aux_rail_regulator_enable(aux),
        .refclk_buffer_enable(refclk));

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(string what, logic exp, logic got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Outputs in their reset state
    task automatic chk_idle();
        chk1("ready", 1'b0, bprs_if_i.board_power_ready);
        chk("enables", 8'h00, bprs_if_i.slot_power_enable);
        chk("link", 8'h00, bprs_if_i.slot_link_reset_n);
        chk("soft", 8'h00, bprs_if_i.slot_soft_reset_n);
        chk1("aux", 1'b0, aux);
        chk1("refclk", 1'b0, refclk);
        chk1("request", 1'b1, bprs_if_i.board_power_request_n);
        chk1("mux", 1'b0, mux);
        chk1("pending", 1'b0, pend);
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_fail++;
            $display("mismatch run length expected 3000 seen %0d", cyc);
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        {nrst, brg, pon, rst0, edit, cdone, sup, hold} = '0;
        bprs_if_i2.board_power_request_n = 1'b1;
        bprs_if_i2.slot_rails_good = 8'h00;
        bprs_if_i2.slot_reset_hold = 8'h00;
        tick(6);
        chk_idle();
        @(negedge clk) nrst = 1'b1;
        // Inputs move only once the first edge after release has passed
        @(negedge clk);
        sup = 8'hFF;
        pon = 1'b1;
        tick(8);
        chk1("request low", 1'b0, bprs_if_i.board_power_request_n);
        chk1("aux up", 1'b1, aux);
        chk1("clocks up", 1'b1, refclk);
        chk("no enable", 8'h00, bprs_if_i.slot_power_enable);
        @(negedge clk) brg = 1'b1;
        for (k = 0; k < 20 && bprs_if_i.slot_rails_good[0] !== 1'b1; k++)
            tick(1);
        for (k = 0; k < 40 && bprs_if_i.slot_link_reset_n[0] !== 1'b1; k++)
            tick(1);
        chk1("release delay", 1'b1, k >= RC && k <= RC + 4);
        chk1("dc on", 1'b1, dc_on);
        chk1("eeprom to slot0", 1'b1, mux);
        // Table of supply and hold patterns
        for (j = 0; j < 6; j++) begin
            @(negedge clk);
            sup = ROWS[j][23:16];
            hold = ROWS[j][15:8];
            tick(RC + 12);
            chk("rails", sup, bprs_if_i.slot_rails_good);
            chk("link", ROWS[j][7:0], bprs_if_i.slot_link_reset_n);
            chk("soft", ROWS[j][7:0], bprs_if_i.slot_soft_reset_n);
            chk("enables", 8'hFF, bprs_if_i.slot_power_enable);
        end
        // Edit deferred, then slot zero reset refreshes the copy
        @(negedge clk) edit = 1'b1;
        @(negedge clk) edit = 1'b0;
        tick(5);
        chk1("pending", 1'b1, pend);
        chk1("mux kept", 1'b1, mux);
        @(negedge clk) rst0 = 1'b1;
        @(negedge clk) rst0 = 1'b0;
        for (k = 0; k < 20 && cstart !== 1'b1; k++)
            tick(1);
        chk1("copy start", 1'b1, cstart);
        chk1("mux to ctl", 1'b0, mux);
        chk1("hold0", 1'b1, bprs_if_i.slot_reset_hold[0]);
        tick(5);
        chk1("link0 held", 1'b0, bprs_if_i.slot_link_reset_n[0]);
        @(negedge clk) cdone = 1'b1;
        @(negedge clk) cdone = 1'b0;
        for (k = 0; k < 20 && fetch !== 1'b1; k++)
            tick(1);
        chk1("fetch", 1'b1, fetch);
        chk1("mux back", 1'b1, mux);
        chk1("hold0 kept", 1'b1, bprs_if_i.slot_reset_hold[0]);
        tick(1);
        chk1("hold0 freed", 1'b0, bprs_if_i.slot_reset_hold[0]);
        chk1("copied", 1'b0, pend);
        tick(RC + 8);
        chk1("link0 back", 1'b1, bprs_if_i.slot_link_reset_n[0]);
        // Edit then power-down copies while off
        @(negedge clk) edit = 1'b1;
        @(negedge clk) edit = 1'b0;
        pon = 1'b0;
        for (k = 0; k < 30 && cstart !== 1'b1; k++)
            tick(1);
        chk1("copy off", 1'b1, cstart);
        chk1("mux off", 1'b0, mux);
        chk("down enables", 8'h00, bprs_if_i.slot_power_enable);
        chk("down link", 8'h00, bprs_if_i.slot_link_reset_n);
        @(negedge clk) cdone = 1'b1;
        @(negedge clk) cdone = 1'b0;
        tick(20);
        chk1("aux off", 1'b0, aux);
        chk1("clocks off", 1'b0, refclk);
        chk1("no fault", 1'b0, fault);
        chk1("pending off", 1'b0, pend);
        // Module that keeps rails good after enable drop
        @(negedge clk) bprs_if_i2.board_power_request_n = 1'b0;
        tick(8);
        @(negedge clk) bprs_if_i2.slot_rails_good = 8'hFF;
        tick(8);
        chk("bad enables", 8'hFF, bprs_if_i2.slot_power_enable);
        @(negedge clk) bprs_if_i2.board_power_request_n = 1'b1;
        for (k = 0; k < 10 && bprs_if_i2.slot_power_enable !== 8'h00; k++)
            tick(1);
        for (k = 0; k < 60 && fault2 !== 1'b1; k++)
            tick(1);
        chk1("timeout", 1'b1, k >= TC && k <= TC + 5);
        chk1("timeout aux", 1'b0, aux2);
        chk1("timeout clocks", 1'b0, refclk2);
        // Reset in mid-run while powered
        @(negedge clk) pon = 1'b1;
        tick(40);
        @(negedge clk) nrst = 1'b0;
        pon = 1'b0;
        tick(1);
        chk_idle();
        @(negedge clk) nrst = 1'b1;
        tick(1);
        chk_idle();
        wrap_up();
    end
endmodule

`default_nettype wire
